/* File: rtl/dbs_pkg.sv */
/*
 * constants shared by the data buffer stack: bus layout, register offsets,
 * field positions, reset values and stack geometry.
 * assumes a 32-bit avalon-mm register bus with byte addresses.
 */
package dbs_pkg;
   // avalon-mm slave geometry
   localparam int BUS_ADDR_W = 8;
   localparam int BUS_DATA_W = 32;
   localparam int BUS_BE_W = 4;
   // stack geometry: four entries, each one data buffer wide
   localparam int BUF_W = 16;
   localparam int DEPTH = 4;
   localparam int PTR_W = 2;
   localparam int OCC_W = 3;
   // register byte offsets
   localparam logic [BUS_ADDR_W-1:0] OFF_PTR = 8'h04;
   localparam logic [BUS_ADDR_W-1:0] OFF_CTRL = 8'h08;
   localparam logic [BUS_ADDR_W-1:0] OFF_STAT = 8'h0C;
   // field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int STAT_OVW_BIT = 4;
   // reset values
   localparam logic [PTR_W-1:0] PTR_RESET = 2'h0;
   localparam logic [OCC_W-1:0] OCC_RESET = 3'h0;
   localparam logic [OCC_W-1:0] OCC_FULL = 3'h4;
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam logic [PTR_W-1:0] PTR_ONE = 2'h1;
   localparam logic [OCC_W-1:0] OCC_ONE = 3'h1;
endpackage : dbs_pkg

/* File: rtl/dbs_pin_sync.sv */
/*
 * three-flop synchroniser with agreement filter for an asynchronous level.
 * assumes the input comes from a pin outside the clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module dbs_pin_sync
   import dbs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw pin and filtered level
   input wire logic pin,
   output logic level_q
);
   logic s1_q; // metastability catcher, read only by s2_q
   logic s2_q;
   logic s3_q;

   // shift chain; the level follows once stages two and three agree
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         s1_q <= pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q) begin
            level_q <= s3_q;
         end
      end
   end
endmodule : dbs_pin_sync
`default_nettype wire

/* File: rtl/dbs_stack_mem.sv */
/*
 * four-entry stack storage, one write port and a registered read port.
 * assumes the caller never writes and reads the same entry in one cycle
 * with a need for the new data (store and load are exclusive upstream).
 */
`timescale 1ns/1ps
`default_nettype none
module dbs_stack_mem
   import dbs_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // write port
   input wire logic wr_en,
   input wire logic [PTR_W-1:0] wr_addr,
   input wire logic [BUF_W-1:0] wr_data,
   // read port, data one cycle after rd_en
   input wire logic rd_en,
   input wire logic [PTR_W-1:0] rd_addr,
   output logic [BUF_W-1:0] rd_data_q
);
   logic [BUF_W-1:0] entry_q [DEPTH]; // contents undefined until first store

   // one register per entry, whole buffer kept intact
   for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk) begin
         if (wr_en && (wr_addr == PTR_W'(i))) begin
            entry_q[i] <= wr_data;
         end
      end
   end

   // registered read; holds last value between loads
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_q <= '0;
      end else if (rd_en) begin
         rd_data_q <= entry_q[rd_addr];
      end
   end
endmodule : dbs_stack_mem
`default_nettype wire

/* File: rtl/dbs_data_buffer_stack.sv */
/*
 * data buffer stack: four 16-bit save slots with a read-only level pointer,
 * driven by store and load pulses from the core, with an avalon-mm slave.
 * assumes store/load pulses are synchronous to clk, one cycle per instruction,
 * and that watchdog and chip-enable resets arrive asynchronously on pins.
 */
`timescale 1ns/1ps
`default_nettype none
module dbs_data_buffer_stack
   import dbs_pkg::*;
(
   // clock and power-on reset
   input wire logic clk,
   input wire logic rst,
   // further reset sources from pins
   input wire logic watchdog_stack_reset,
   input wire logic ce_reset,
   // core instruction strobes and buffer
   input wire logic store_to_stack_instr,
   input wire logic load_from_stack_instr,
   input wire logic [BUF_W-1:0] data_buffer,
   // restore path back to the core
   output logic [BUF_W-1:0] data_buffer_restore,
   output logic restore_valid_q,
   output logic [PTR_W-1:0] stack_level_q,
   output logic overwrite_q,
   // avalon-mm slave
   input wire logic [BUS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [BUS_DATA_W-1:0] avs_writedata,
   input wire logic [BUS_BE_W-1:0] avs_byteenable,
   output logic [BUS_DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest
);

   // synchronised reset levels
   logic wdt_rst_lvl; // watchdog/stack reset after filtering
   logic ce_rst_lvl; // chip-enable reset after filtering

   // stack state
   logic [PTR_W-1:0] ptr_q; // level pointer
   logic [PTR_W-1:0] ptr_d;
   logic [OCC_W-1:0] occ_q; // saved entries, saturates at four
   logic [OCC_W-1:0] occ_d;

   // software state
   logic ctrl_en_q; // stack operations allowed
   logic ovw_sticky_q; // an overwrite happened since last clear
   logic ovw_sticky_d;

   // bus slave state
   logic wait_q; // drives waitrequest
   logic [BUS_DATA_W-1:0] rdata_q;

   // decoded strobes
   wire do_store;
   wire do_load;
   wire lvl_clear;
   wire [PTR_W-1:0] ptr_inc;
   wire [PTR_W-1:0] ptr_dec;
   wire ovw_event;

   // bus decode
   wire bus_req;
   wire bus_take;
   wire sel_ptr;
   wire sel_ctrl;
   wire sel_stat;
   wire wr_ctrl;
   wire wr_stat_clr;
   wire [BUS_DATA_W-1:0] rd_mux;

   // watchdog/stack reset pin crossing
   dbs_pin_sync u_wdt_sync (
      .clk(clk),
      .rst(rst),
      .pin(watchdog_stack_reset),
      .level_q(wdt_rst_lvl)
   );

   // chip-enable reset pin crossing
   dbs_pin_sync u_ce_sync (
      .clk(clk),
      .rst(rst),
      .pin(ce_reset),
      .level_q(ce_rst_lvl)
   );

   // any secondary reset clears the level bits
   assign lvl_clear = wdt_rst_lvl | ce_rst_lvl;

   // store wins if the core ever raises both strobes together;
   // the core never should, but a defined answer beats a corrupt stack
   assign do_store = store_to_stack_instr & ctrl_en_q & ~lvl_clear;
   assign do_load = load_from_stack_instr & ~store_to_stack_instr & ctrl_en_q & ~lvl_clear;

   // two-bit arithmetic wraps by itself, which gives the modulo-four count
   assign ptr_inc = ptr_q + PTR_ONE;
   assign ptr_dec = ptr_q - PTR_ONE;

   // a store with all four slots live destroys the oldest save
   assign ovw_event = do_store & (occ_q == OCC_FULL);

   // storage: store writes at the current level, load reads one below
   // so the last saved word comes back first
   dbs_stack_mem u_mem (
      .clk(clk),
      .rst(rst),
      .wr_en(do_store),
      .wr_addr(ptr_q),
      .wr_data(data_buffer),
      .rd_en(do_load),
      .rd_addr(ptr_dec),
      .rd_data_q(data_buffer_restore)
   );

   // next pointer value
   always_comb begin
      ptr_d = ptr_q;
      if (lvl_clear) begin
         ptr_d = PTR_RESET;
      end else if (do_store) begin
         ptr_d = ptr_inc;
      end else if (do_load) begin
         ptr_d = ptr_dec;
      end
   end

   // next occupancy; for the overwrite flag and the status register read, not visible to the core
   always_comb begin
      occ_d = occ_q;
      if (lvl_clear) begin
         occ_d = OCC_RESET;
      end else if (do_store && (occ_q != OCC_FULL)) begin
         occ_d = occ_q + OCC_ONE;
      end else if (do_load && (occ_q != OCC_RESET)) begin
         occ_d = occ_q - OCC_ONE;
      end
   end

   // pointer and occupancy; no bus path writes them
   always_ff @(posedge clk) begin
      if (rst) begin
         ptr_q <= PTR_RESET;
         occ_q <= OCC_RESET;
      end else begin
         ptr_q <= ptr_d;
         occ_q <= occ_d;
      end
   end

   // core-side status registers
   always_ff @(posedge clk) begin
      if (rst) begin
         stack_level_q <= PTR_RESET;
         restore_valid_q <= 1'b0;
         overwrite_q <= 1'b0;
      end else begin
         stack_level_q <= ptr_d;
         restore_valid_q <= do_load; // lines up with registered read
         overwrite_q <= ovw_event;
      end
   end

   // bus request decode
   assign bus_req = avs_read | avs_write;
   assign bus_take = bus_req & wait_q; // first cycle a request is seen
   assign sel_ptr = (avs_address == OFF_PTR);
   assign sel_ctrl = (avs_address == OFF_CTRL);
   assign sel_stat = (avs_address == OFF_STAT);
   assign wr_ctrl = bus_take & avs_write & sel_ctrl & avs_byteenable[0];
   assign wr_stat_clr = bus_take & avs_write & sel_stat & avs_byteenable[0]
      & avs_writedata[STAT_OVW_BIT];

   // read selection; unmapped offsets and reserved bits read zero
   assign rd_mux = sel_ptr ? {{(BUS_DATA_W - PTR_W){1'b0}}, ptr_q}
      : sel_ctrl ? {{(BUS_DATA_W - 1){1'b0}}, ctrl_en_q}
      : sel_stat ? {{(BUS_DATA_W - STAT_OVW_BIT - 1){1'b0}}, ovw_sticky_q,
         {(STAT_OVW_BIT - OCC_W){1'b0}}, occ_q}
      : '0;

   // sticky overwrite: a new event wins over a clear in the same cycle
   always_comb begin
      ovw_sticky_d = ovw_sticky_q;
      if (wr_stat_clr) begin
         ovw_sticky_d = 1'b0;
      end
      if (ovw_event) begin
         ovw_sticky_d = 1'b1;
      end
   end

   // control and sticky status
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_en_q <= CTRL_EN_RESET;
         ovw_sticky_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_en_q <= avs_writedata[CTRL_EN_BIT];
         end
         ovw_sticky_q <= ovw_sticky_d;
      end
   end

   // waitrequest drops for exactly one cycle per request;
   // costs one cycle of latency but keeps every output on a flop
   always_ff @(posedge clk) begin
      if (rst) begin
         wait_q <= 1'b1;
         rdata_q <= '0;
      end else if (bus_take) begin
         wait_q <= 1'b0;
         rdata_q <= avs_read ? rd_mux : '0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   // bus outputs straight from flops
   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;

endmodule : dbs_data_buffer_stack
`default_nettype wire

/* File: dv/dbs_asserts.sv */
/* port checks for the data buffer stack.
   assumes one clk domain and a sync, active-high rst. */
`timescale 1ns/1ps
`default_nettype none
module dbs_chk
   import dbs_pkg::*;
(
   // clock and resets
   input wire logic clk,
   input wire logic rst,
   input wire logic watchdog_stack_reset,
   input wire logic ce_reset,
   // core side
   input wire logic store_to_stack_instr,
   input wire logic load_from_stack_instr,
   input wire logic restore_valid_q,
   input wire logic [PTR_W-1:0] stack_level_q,
   // bus side
   input wire logic [BUS_ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [BUS_DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest
);
   default clocking @(posedge clk); endclocking
   // pin resets mask strobes, so checks pause
   default disable iff (rst || watchdog_stack_reset || ce_reset);
   chk_store_step: assert property (
      store_to_stack_instr |=> stack_level_q == $past(stack_level_q) + PTR_ONE)
      else $error("store did not raise level");
   chk_load_step: assert property (
      load_from_stack_instr && !store_to_stack_instr
      |=> stack_level_q == $past(stack_level_q) - PTR_ONE)
      else $error("load did not lower level");
   chk_idle_hold: assert property (
      !(store_to_stack_instr || load_from_stack_instr) |=> $stable(stack_level_q))
      else $error("level moved while idle");
   chk_valid_cause: assert property (
      restore_valid_q |-> $past(load_from_stack_instr) && !$past(store_to_stack_instr))
      else $error("restore valid without load");
   chk_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   chk_wait_short: assert property (
      !avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_ptr_read: assert property (
      avs_read && !avs_waitrequest && avs_address == OFF_PTR
      |-> avs_readdata == {{(BUS_DATA_W-PTR_W){1'b0}}, stack_level_q})
      else $error("pointer read mismatch");
   chk_rst_clear: assert property (
      $fell(rst) |-> stack_level_q == PTR_RESET)
      else $error("level not cleared by reset");
endmodule : dbs_chk
bind dbs_data_buffer_stack dbs_chk i_dbs_chk (.clk, .rst, .watchdog_stack_reset,
   .ce_reset, .store_to_stack_instr, .load_from_stack_instr, .restore_valid_q,
   .stack_level_q, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest);
`default_nettype wire

/* File: dv/dbs_core_model.sv */
/* core model: store and load strobes with a buffer value.
   assumes the stack takes one strobe per clk edge. */
`timescale 1ns/1ps
`default_nettype none
module dbs_core_model
   import dbs_pkg::*;
(
   // clock in
   input wire logic clk,
   // strobes and buffer out
   output logic store_q,
   output logic load_q,
   output logic [BUF_W-1:0] data_q
);
   initial begin
      store_q = 1'b0;
      load_q = 1'b0;
      data_q = '0;
   end
   // one store; buffer then shows its inverse so stale data is never hit
   task automatic push(input logic [BUF_W-1:0] v);
      @(posedge clk);
      store_q <= 1'b1;
      data_q <= v;
      @(posedge clk);
      store_q <= 1'b0;
      data_q <= ~v;
   endtask : push
   // one load
   task automatic pop();
      @(posedge clk);
      load_q <= 1'b1;
      @(posedge clk);
      load_q <= 1'b0;
   endtask : pop
   // handler entry saves buffer and address by hand
   task automatic isr_save(input logic [BUF_W-1:0] b, input logic [BUF_W-1:0] a);
      push(b);
      push(a);
   endtask : isr_save
endmodule : dbs_core_model
`default_nettype wire

/* File: dv/tb_top.sv */
/* self-checking bench for the data buffer stack.
   assumes the core model on the strobes and an avalon master here. */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import dbs_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wd = 1'b0;
   logic ce = 1'b0;
   wire logic st, ld, vld, ovw, a_wait;
   wire logic [BUF_W-1:0] dbuf, rdat;
   wire logic [PTR_W-1:0] lvl;
   logic [BUS_ADDR_W-1:0] a_adr = '0;
   logic a_rd = 1'b0;
   logic a_wr = 1'b0;
   logic [BUS_DATA_W-1:0] a_wd = '0;
   wire logic [BUS_DATA_W-1:0] a_q;
   logic [BUS_DATA_W-1:0] q;
   int n_fail = 0;
   int cmp_count = 0;
   int cyc = 0;
   logic [BUF_W-1:0] v [5] = '{16'hA5C3, 16'h5A3C, 16'hF00F, 16'h0FF0, 16'h8001};
   always #12.5 clk = ~clk;
   dbs_core_model i_dbs_core_model (.clk, .store_q(st), .load_q(ld), .data_q(dbuf));
   dbs_data_buffer_stack i_dbs_data_buffer_stack (.clk, .rst,
      .watchdog_stack_reset(wd), .ce_reset(ce), .store_to_stack_instr(st),
      .load_from_stack_instr(ld), .data_buffer(dbuf), .data_buffer_restore(rdat),
      .restore_valid_q(vld), .stack_level_q(lvl), .overwrite_q(ovw),
      .avs_address(a_adr), .avs_read(a_rd), .avs_write(a_wr), .avs_writedata(a_wd),
      .avs_byteenable(4'hF), .avs_readdata(a_q), .avs_waitrequest(a_wait));
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("[ERR] %s exp %h got %h", n, e, g);
         n_fail++;
      end
   endtask : chk
   // one avalon transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      a_adr <= a;
      a_wd <= d;
      a_rd <= !w;
      a_wr <= w;
      do @(posedge clk); while (a_wait !== 1'b0);
      q = a_q;
      a_rd <= 1'b0;
      a_wr <= 1'b0;
   endtask : bus
   task automatic t_stack();
      for (int i = 0; i < 5; i++) begin
         i_dbs_core_model.push(v[i]);
         @(negedge clk);
         chk("level", (i + 1) % 4, lvl);
         chk("overwrite", i == 4, ovw);
      end
      bus(0, OFF_PTR, 0);
      chk("ptr", 1, q);
      for (int i = 0; i < 4; i++) begin
         i_dbs_core_model.pop();
         @(negedge clk);
         chk("restore", v[4-i], rdat);
         chk("valid", 1, vld);
         chk("level", (4 - i) % 4, lvl);
      end
   endtask : t_stack
   task automatic t_ro();
      bus(1, OFF_PTR, 32'h3);
      bus(0, OFF_PTR, 0);
      chk("ptr ro", 1, q);
      bus(0, 8'h40, 0);
      chk("unmapped", 0, q);
   endtask : t_ro
   task automatic t_pin();
      for (int k = 0; k < 2; k++) begin
         i_dbs_core_model.push(16'h1234);
         @(posedge clk);
         {wd, ce} <= k ? 2'b10 : 2'b01;
         repeat (8) @(posedge clk);
         {wd, ce} <= 2'b00;
         repeat (8) @(posedge clk);
         bus(0, OFF_PTR, 0);
         chk("pin clear", 0, q);
      end
   endtask : t_pin
   task automatic t_isr();
      i_dbs_core_model.isr_save(16'hBEEF, 16'h0123);
      i_dbs_core_model.pop();
      @(negedge clk);
      chk("isr addr", 16'h0123, rdat);
      i_dbs_core_model.pop();
      @(negedge clk);
      chk("isr buf", 16'hBEEF, rdat);
   endtask : t_isr
   // sticky overwrite from the fifth store survives pin resets; write one clears it
   task automatic t_stat();
      bus(0, OFF_STAT, 0);
      chk("ovw sticky", 32'h1 << STAT_OVW_BIT, q);
      bus(1, OFF_STAT, 32'h1 << STAT_OVW_BIT);
      bus(0, OFF_STAT, 0);
      chk("ovw cleared", 0, q);
      bus(0, OFF_CTRL, 0);
      chk("ctrl en", 1, q);
   endtask : t_stat
   task automatic stop_test();
      $display("checks %0d errors %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         stop_test();
      end
   end
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      bus(0, OFF_PTR, 0);
      chk("ptr reset", 0, q);
      t_stack();
      t_ro();
      t_pin();
      t_isr();
      t_stat();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
